/* core/scoc_pkg.sv */
package scoc_pkg;

    // ************************************************************
    // Register map: index times word size gives the byte address
    // ************************************************************
    localparam int unsigned SCOC_WORD_BYTES = 4;
    localparam int unsigned SCOC_IDX_CTRL = 0;
    localparam int unsigned SCOC_IDX_IRQ_STATUS = 2;
    localparam int unsigned SCOC_IDX_IRQ_MASK = 3;
    localparam int unsigned SCOC_IDX_SYNTH_STAT = 4;
    localparam int unsigned SCOC_IDX_FREQ_DEV = 5;
    localparam int unsigned SCOC_IDX_R1 = 6;
    localparam int unsigned SCOC_IDX_P1 = 7;
    localparam int unsigned SCOC_IDX_S1 = 8;
    localparam int unsigned SCOC_IDX_R2 = 9;
    localparam int unsigned SCOC_IDX_P2 = 10;
    localparam int unsigned SCOC_IDX_S2 = 11;
    localparam int unsigned SCOC_NUM_DIV = 6;

    // ************************************************************
    // Control register fields
    // ************************************************************
    localparam int unsigned SCOC_CLKOUT_EN_BIT = 0;
    localparam int unsigned SCOC_CLKDIV_LSB = 1;
    localparam int unsigned SCOC_CLKDIV_W = 3;
    localparam int unsigned SCOC_LOCK_PIN_EN_BIT = 4;
    localparam int unsigned SCOC_SET_SEL_BIT = 5;
    localparam int unsigned SCOC_BAND_LSB = 8;
    localparam int unsigned SCOC_BAND_W = 2;
    localparam int unsigned SCOC_TRIM_LSB = 10;
    localparam int unsigned SCOC_TRIM_W = 2;
    localparam logic [31:0] SCOC_CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] SCOC_CTRL_MASK = 32'h0000_0F3F;

    // ************************************************************
    // Interrupt status bits and divider limits
    // ************************************************************
    localparam int unsigned SCOC_IRQ_W = 3;
    localparam int unsigned SCOC_ST_LOCK_BIT = 0;
    localparam int unsigned SCOC_ST_UNLOCK_BIT = 1;
    localparam int unsigned SCOC_ST_RANGE_BIT = 2;
    localparam int unsigned SCOC_SYN_LIVE_BIT = 16;
    localparam int unsigned SCOC_SYN_SET_BIT = 17;
    localparam logic [15:0] SCOC_N_MULT = 16'h004B;
    localparam logic [7:0] SCOC_R_MIN = 8'h40;
    localparam logic [7:0] SCOC_R_MAX = 8'hA9;
    localparam logic [7:0] SCOC_DIV_RESET = 8'h00;
    localparam logic [7:0] SCOC_FDEV_RESET = 8'h00;

    // ************************************************************
    // Bus constants and enumerations
    // ************************************************************
    localparam logic [1:0] SCOC_HTRANS_NONSEQ = 2'h2;
    localparam logic SCOC_HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        SCOC_OFS_NONE = 2'b00,
        SCOC_OFS_FDEV = 2'b01,
        SCOC_OFS_IF2 = 2'b10
    } scoc_offset_t;

    typedef enum logic {
        SCOC_BUS_IDLE = 1'b0,
        SCOC_BUS_DATA = 1'b1
    } scoc_bus_t;

endpackage

/* core/scoc_sync2.sv */
`timescale 1ns/1ns
module scoc_sync2 import scoc_pkg::*; #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

/* core/scoc_clkdiv.sv */
`timescale 1ns/1ns
module scoc_clkdiv import scoc_pkg::*; #(
    parameter int unsigned DIV_W = SCOC_CLKDIV_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [DIV_W-1:0] div_sel,
    output logic clk_out
);
    logic [DIV_W-1:0] cnt_reg;

    // Half period lasts div_sel+1 clocks; a registered output
    // cannot run at the full reference rate, so the top is half
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            clk_out <= 1'b0;
        end else if (!enable) begin
            cnt_reg <= '0;
            clk_out <= 1'b0;
        end else if (cnt_reg >= div_sel) begin
            cnt_reg <= '0;
            clk_out <= ~clk_out;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule

/* core/scoc_top.sv */
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
// Functional notes
// [RL1] Enable bit drives divided reference on output
// [RL2] Divider field sets output clock ratio
// [RL3] Output off in sleep, enabled at reset
// [RL4] Lock flag sticky, cleared by writing one
// [RL5] Lock pin mirrors flag when enabled
// [RL6] Two divider sets at indices six-eleven
// [RL7] Software picks band code per channel
// [RL8] Two-bit VCO trim field, resets to zero
// [RL9] Software keeps R and S within limits
// [RL10] Loop word is 75*(P+1)+S over R+1
// [RL11] OOK offset by deviation or IF2
// [RL12] Software sets R near one-nineteen
module scoc_top import scoc_pkg::*; #(
    parameter int unsigned ADDR_W = 8,
    parameter int unsigned DIV_W = SCOC_CLKDIV_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic synth_lock_raw,
    input wire logic sleep_mode,
    input wire logic ook_mode,
    input wire logic tx_active,
    output logic clk_out,
    output logic lock_pin,
    output logic irq,
    output logic [7:0] r_div,
    output logic [15:0] n_word,
    output logic [SCOC_BAND_W-1:0] band_select_field,
    output logic [SCOC_TRIM_W-1:0] vco_trim_field,
    output logic [7:0] freq_deviation_field,
    output logic [1:0] lo_offset_sel
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (ADDR_W < 6) begin : g_bad_addr
        $error("scoc_top: ADDR_W too small for the register map");
    end
    if (DIV_W != SCOC_CLKDIV_W) begin : g_bad_div
        $error("scoc_top: DIV_W must match the control field width");
    end

    // ************************************************************
    // Declarations
    // ************************************************************
    scoc_bus_t bus_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic write_reg;
    logic [31:0] ctrl_reg;
    logic [SCOC_IRQ_W-1:0] status_reg;
    logic [SCOC_IRQ_W-1:0] status_next;
    logic [SCOC_IRQ_W-1:0] mask_reg;
    logic [7:0] fdev_reg;
    logic [7:0] div_reg [SCOC_NUM_DIV];
    logic lock_s;
    logic lock_d_reg;
    logic [SCOC_IRQ_W-1:0] events;
    logic [SCOC_IRQ_W-1:0] w1c;
    logic accept;
    logic wr_en;
    logic [ADDR_W-1:0] idx_addr;
    logic [31:0] rd_mux;
    logic set_sel;
    logic [7:0] r_act;
    logic [7:0] p_act;
    logic [7:0] s_act;
    logic range_bad;
    logic clkout_run;
    logic [31:0] synth_stat;

    // ************************************************************
    // AHB-Lite slave: one wait state per transfer
    // ************************************************************
    assign accept = hsel && hready && (htrans == SCOC_HTRANS_NONSEQ);
    assign wr_en = (bus_reg == SCOC_BUS_DATA) && write_reg;
    assign idx_addr = addr_reg >> 2;

    // The wait state lets a write land before any later read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_reg <= SCOC_BUS_IDLE;
            addr_reg <= '0;
            write_reg <= 1'b0;
            hreadyout <= 1'b1;
        end else begin
            case (bus_reg)
                SCOC_BUS_IDLE: begin
                    if (accept) begin
                        bus_reg <= SCOC_BUS_DATA;
                        addr_reg <= haddr;
                        write_reg <= hwrite;
                        hreadyout <= 1'b0;
                    end
                end
                SCOC_BUS_DATA: begin
                    bus_reg <= SCOC_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                default: begin
                    bus_reg <= SCOC_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= SCOC_HRESP_OKAY;
        end else begin
            hresp <= SCOC_HRESP_OKAY;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    assign synth_stat = {14'h0000, set_sel, lock_s, n_word};

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx_addr)
            ADDR_W'(SCOC_IDX_CTRL): rd_mux = ctrl_reg;
            ADDR_W'(SCOC_IDX_IRQ_STATUS): rd_mux = 32'(status_reg);
            ADDR_W'(SCOC_IDX_IRQ_MASK): rd_mux = 32'(mask_reg);
            ADDR_W'(SCOC_IDX_SYNTH_STAT): rd_mux = synth_stat;
            ADDR_W'(SCOC_IDX_FREQ_DEV): rd_mux = 32'(fdev_reg);
            ADDR_W'(SCOC_IDX_R1): rd_mux = 32'(div_reg[0]);
            ADDR_W'(SCOC_IDX_P1): rd_mux = 32'(div_reg[1]);
            ADDR_W'(SCOC_IDX_S1): rd_mux = 32'(div_reg[2]);
            ADDR_W'(SCOC_IDX_R2): rd_mux = 32'(div_reg[3]);
            ADDR_W'(SCOC_IDX_P2): rd_mux = 32'(div_reg[4]);
            ADDR_W'(SCOC_IDX_S2): rd_mux = 32'(div_reg[5]);
            default: rd_mux = 32'h0000_0000;
        endcase
        if (addr_reg[1:0] != 2'h0) begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if ((bus_reg == SCOC_BUS_DATA) && !write_reg) begin
            hrdata <= rd_mux;
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    // Clock output enable comes up set with no write needed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= SCOC_CTRL_RESET; // see [RL3]
        end else if (wr_en && (idx_addr == ADDR_W'(SCOC_IDX_CTRL))) begin
            ctrl_reg <= hwdata & SCOC_CTRL_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fdev_reg <= SCOC_FDEV_RESET;
            mask_reg <= '0;
        end else if (wr_en) begin
            if (idx_addr == ADDR_W'(SCOC_IDX_FREQ_DEV)) begin
                fdev_reg <= hwdata[7:0];
            end
            if (idx_addr == ADDR_W'(SCOC_IDX_IRQ_MASK)) begin
                mask_reg <= hwdata[SCOC_IRQ_W-1:0];
            end
        end
    end

    // Six divider bytes, one word each
    for (genvar gi = 0; gi < SCOC_NUM_DIV; gi++) begin : g_div
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                div_reg[gi] <= SCOC_DIV_RESET;
            end else if (wr_en && (idx_addr == ADDR_W'(SCOC_IDX_R1 + gi))) begin
                div_reg[gi] <= hwdata[7:0]; // see [RL6]
            end
        end
    end

    // ************************************************************
    // Lock detection and interrupt status
    // ************************************************************
    scoc_sync2 #(
        .W(1)
    ) u_lock_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d(synth_lock_raw),
        .q(lock_s)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_d_reg <= 1'b0;
        end else begin
            lock_d_reg <= lock_s;
        end
    end

    assign set_sel = ctrl_reg[SCOC_SET_SEL_BIT];
    assign r_act = set_sel ? div_reg[3] : div_reg[0];
    assign p_act = set_sel ? div_reg[4] : div_reg[1];
    assign s_act = set_sel ? div_reg[5] : div_reg[2];
    // Guards against software leaving the divider rules broken
    assign range_bad = (r_act < SCOC_R_MIN) || (r_act > SCOC_R_MAX)
        || ({1'b0, s_act} >= ({1'b0, p_act} + 9'h001)); // see [RL9]

    always_comb begin
        events = '0;
        events[SCOC_ST_LOCK_BIT] = lock_s;
        events[SCOC_ST_UNLOCK_BIT] = lock_d_reg && !lock_s;
        events[SCOC_ST_RANGE_BIT] = range_bad;
    end

    assign w1c = (wr_en && (idx_addr == ADDR_W'(SCOC_IDX_IRQ_STATUS)))
        ? hwdata[SCOC_IRQ_W-1:0] : '0;
    // Set wins over a clear in the same cycle
    assign status_next = (status_reg & ~w1c) | events; // see [RL4]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next; // see [RL4]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
            lock_pin <= 1'b0;
        end else begin
            irq <= |(status_next & mask_reg);
            lock_pin <= ctrl_reg[SCOC_LOCK_PIN_EN_BIT]
                && status_next[SCOC_ST_LOCK_BIT]; // see [RL5]
        end
    end

    // ************************************************************
    // Reference clock output
    // ************************************************************
    assign clkout_run = ctrl_reg[SCOC_CLKOUT_EN_BIT] && !sleep_mode; // see [RL1] [RL3]

    scoc_clkdiv #(
        .DIV_W(DIV_W)
    ) u_clkdiv (
        .clk(hclk),
        .rst_n(hresetn),
        .enable(clkout_run),
        .div_sel(ctrl_reg[SCOC_CLKDIV_LSB +: DIV_W]), // see [RL2]
        .clk_out(clk_out)
    );

    // ************************************************************
    // Synthesizer words toward the analog loop
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_div <= SCOC_DIV_RESET;
            n_word <= 16'h0000;
            band_select_field <= '0;
            vco_trim_field <= '0;
            freq_deviation_field <= SCOC_FDEV_RESET;
        end else begin
            r_div <= r_act; // see [RL10]
            n_word <= SCOC_N_MULT * (16'(p_act) + 16'h0001) + 16'(s_act); // see [RL10]
            band_select_field <= ctrl_reg[SCOC_BAND_LSB +: SCOC_BAND_W];
            vco_trim_field <= ctrl_reg[SCOC_TRIM_LSB +: SCOC_TRIM_W]; // see [RL8]
            freq_deviation_field <= fdev_reg;
        end
    end

    // OOK shifts the centre below the loop frequency
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lo_offset_sel <= SCOC_OFS_NONE;
        end else if (!ook_mode) begin
            lo_offset_sel <= SCOC_OFS_NONE;
        end else if (tx_active) begin
            lo_offset_sel <= SCOC_OFS_FDEV; // see [RL11]
        end else begin
            lo_offset_sel <= SCOC_OFS_IF2; // see [RL11]
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic ctrl_written_reg;
    logic [DIV_W:0] hold_cnt_reg;
    logic seen_edge_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_written_reg <= 1'b0;
            hold_cnt_reg <= '0;
            seen_edge_reg <= 1'b0;
        end else begin
            if (wr_en && (idx_addr == ADDR_W'(SCOC_IDX_CTRL))) begin
                ctrl_written_reg <= 1'b1;
            end
            hold_cnt_reg <= (clk_out != $past(clk_out)) ? '0 : hold_cnt_reg + 1'b1;
            seen_edge_reg <= clkout_run && $stable(ctrl_reg)
                && (seen_edge_reg || (clk_out != $past(clk_out)));
        end
    end

    sequence s_addr_phase;
        accept;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    a_bus_one_wait: assert property (s_addr_phase |=> s_one_wait)
        else $error("bus transfer did not take exactly one wait state");
    a_clkout_off_low: assert property (!clkout_run |=> !clk_out) // see [RL1]
        else $error("clock output toggled while disabled or asleep");
    a_clkout_half_period: assert property ( // see [RL2]
        seen_edge_reg && clkout_run && $past(clkout_run)
        && $stable(ctrl_reg) && $changed(clk_out)
        |-> hold_cnt_reg == {1'b0, ctrl_reg[SCOC_CLKDIV_LSB +: DIV_W]})
        else $error("clock output half period does not match divider");
    a_clkout_reset_on: assert property (!ctrl_written_reg // see [RL3]
        |-> ctrl_reg[SCOC_CLKOUT_EN_BIT])
        else $error("clock output enable not set after reset");
    a_lock_flag_set: assert property (lock_s |=> status_reg[SCOC_ST_LOCK_BIT]) // see [RL4]
        else $error("lock flag not set by lock");
    a_lock_flag_sticky: assert property ( // see [RL4]
        status_reg[SCOC_ST_LOCK_BIT] && !w1c[SCOC_ST_LOCK_BIT]
        |=> status_reg[SCOC_ST_LOCK_BIT] [*1])
        else $error("lock flag dropped without a clear");
    a_lock_pin_follow: assert property ( // see [RL5]
        !ctrl_reg[SCOC_LOCK_PIN_EN_BIT] |=> !lock_pin)
        else $error("lock pin active while disabled");
    a_div_set_pick: assert property (1'b1 |=> r_div == // see [RL6]
        ($past(ctrl_reg[SCOC_SET_SEL_BIT]) ? $past(div_reg[3]) : $past(div_reg[0])))
        else $error("reference divider from the wrong set");
    a_trim_reset_zero: assert property (!ctrl_written_reg ##1 !ctrl_written_reg // see [RL8]
        |-> vco_trim_field == '0)
        else $error("trim field not zero before first write");
    a_n_word_value: assert property (hresetn |=> n_word == // see [RL10]
        SCOC_N_MULT * (16'($past(p_act)) + 16'h0001) + 16'($past(s_act)))
        else $error("loop word mismatch");
    a_ook_offset: assert property (ook_mode |=> // see [RL11]
        lo_offset_sel == ($past(tx_active) ? SCOC_OFS_FDEV : SCOC_OFS_IF2))
        else $error("OOK offset selection wrong");
    a_irq_level: assert property (irq == |($past(status_next) & $past(mask_reg))) // see [RL4]
        else $error("interrupt level mismatch");

endmodule

/* verif/scoc_synth_model.sv */
`timescale 1ns/1ns
// ********
// Synthesizer loop stand-in: lock drops on every retune
// ********
module scoc_synth_model #(
    parameter int unsigned LOCK_DLY = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] r_div,
    input wire logic [15:0] n_word,
    input wire logic kill_lock,
    output logic synth_lock_raw
);
    logic [23:0] last_word;
    int unsigned settle_cnt;

    // Lock only after the loop word has sat still, as a real loop would
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_word <= 24'h000000;
            settle_cnt <= 0;
            synth_lock_raw <= 1'b0;
        end else if (kill_lock || {r_div, n_word} != last_word) begin
            last_word <= {r_div, n_word};
            settle_cnt <= 0;
            synth_lock_raw <= 1'b0;
        end else if (settle_cnt < LOCK_DLY) begin
            settle_cnt <= settle_cnt + 1;
        end else begin
            synth_lock_raw <= 1'b1;
        end
    end
endmodule

/* verif/synth_clock_out_control_test.sv */
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    $display("mismatch %s exp %h got %h", nm, exp, got); error_cnt++; end end
module synth_clock_out_control_test import scoc_pkg::*; ;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr, r_div, freq_deviation_field;
    logic [1:0] htrans, band_select_field, vco_trim_field, lo_offset_sel;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic synth_lock_raw, sleep_mode, ook_mode, tx_active, kill_lock, clk_out, lock_pin, irq;
    logic [15:0] n_word;
    int error_cnt = 0;
    int compares = 0;

    assign hready = hreadyout;
    always #4 hclk = ~hclk;

    scoc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .synth_lock_raw(synth_lock_raw),
        .sleep_mode(sleep_mode), .ook_mode(ook_mode), .tx_active(tx_active), .clk_out(clk_out),
        .lock_pin(lock_pin), .irq(irq), .r_div(r_div), .n_word(n_word),
        .band_select_field(band_select_field), .vco_trim_field(vco_trim_field),
        .freq_deviation_field(freq_deviation_field), .lo_offset_sel(lo_offset_sel));

    scoc_synth_model synth_u (.hclk(hclk), .hresetn(hresetn), .r_div(r_div), .n_word(n_word),
        .kill_lock(kill_lock), .synth_lock_raw(synth_lock_raw));

    // ********
    // Verdict, timeouts and bus tasks
    // ********
    task automatic report_and_stop();
        if (error_cnt == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic give_up(input int k, input int lim);
        if (k >= lim) begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        give_up(k, 20);
    endtask

    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
            output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= SCOC_HTRANS_NONSEQ;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        `CHK("hresp", SCOC_HRESP_OKAY, hresp)
    endtask

    task automatic wr(input int idx, input logic [31:0] v);
        logic [31:0] unused;
        ahb(8'(idx * SCOC_WORD_BYTES), 1'b1, v, unused);
    endtask

    task automatic rd(input int idx, output logic [31:0] v);
        ahb(8'(idx * SCOC_WORD_BYTES), 1'b0, 32'h00000000, v);
    endtask

    task automatic half_period(output int n);
        int k;
        n = 0;
        k = 0;
        while (clk_out !== 1'b0 && k < 64) begin @(posedge hclk); k++; end
        while (clk_out !== 1'b1 && k < 64) begin @(posedge hclk); k++; end
        while (clk_out === 1'b1 && k < 64) begin @(posedge hclk); k++; n++; end
        give_up(k, 64);
    endtask

    task automatic stays_low();
        tick(3);
        for (int i = 0; i < 12; i++) begin
            @(posedge hclk);
            `CHK("clk low", 1'b0, clk_out)
        end
    endtask

    task automatic wait_lock(input logic v);
        int k;
        k = 0;
        while (synth_lock_raw !== v && k < 100) begin @(posedge hclk); k++; end
        give_up(k, 100);
        tick(5);
    endtask

    function automatic logic [15:0] n_calc(logic [7:0] p, logic [7:0] s);
        return 16'(SCOC_N_MULT * ({8'h00, p} + 16'h0001) + {8'h00, s});
    endfunction

    function automatic logic [1:0] lo_exp(logic o, logic t);
        return !o ? SCOC_OFS_NONE : (t ? SCOC_OFS_FDEV : SCOC_OFS_IF2);
    endfunction

    initial begin
        repeat (50000) @(posedge hclk);
        give_up(1, 1);
    end

    // ********
    // Main sequence
    // ********
    initial begin
        logic [31:0] d;
        logic [7:0] rr, pp, ss;
        logic [7:0] r_keep;
        logic [7:0] rtab [6];
        logic [7:0] stab [6];
        logic etab [6];
        logic [1:0] btab [4];
        int n;
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        sleep_mode = 1'b0;
        ook_mode = 1'b0;
        tx_active = 1'b0;
        kill_lock = 1'b0;
        void'($urandom(6));
        rtab = '{8'h3F, 8'h40, 8'hA9, 8'hAA, 8'h77, 8'h77};
        stab = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h11, 8'h10};
        etab = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        btab = '{2'h2, 2'h0, 2'h1, 2'h2};
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(SCOC_IDX_CTRL, d);
        `CHK("ctrl rst", SCOC_CTRL_RESET, d)
        `CHK("trim rst", 2'h0, vco_trim_field)
        half_period(n);
        `CHK("clk div0", 1, n)
        for (int dv = 0; dv < 8; dv++) begin
            wr(SCOC_IDX_CTRL, 32'h1 | (32'(dv) << SCOC_CLKDIV_LSB));
            half_period(n);
            `CHK("clk half", dv + 1, n)
        end
        sleep_mode <= 1'b1;
        stays_low();
        sleep_mode <= 1'b0;
        half_period(n);
        `CHK("wake clk", 8, n)
        wr(SCOC_IDX_CTRL, 32'h0);
        stays_low();
        // Random legal sets; the bench keeps R and S within limits
        for (int set = 0; set < 2; set++) begin
            rr = 8'(64 + $urandom % 106);
            pp = 8'($urandom);
            ss = 8'($urandom % (pp + 1));
            if (set == 0) r_keep = rr;
            wr(SCOC_IDX_R1 + 3 * set, {24'h0, rr});
            wr(SCOC_IDX_P1 + 3 * set, {24'h0, pp});
            wr(SCOC_IDX_S1 + 3 * set, {24'h0, ss});
            wr(SCOC_IDX_CTRL, 32'(set) << SCOC_SET_SEL_BIT);
            tick(2);
            `CHK("r_div", rr, r_div)
            `CHK("n_word", n_calc(pp, ss), n_word)
            wr(SCOC_IDX_SYNTH_STAT, 32'hFFFFFFFF);
            rd(SCOC_IDX_SYNTH_STAT, d);
            `CHK("stat word", n_calc(pp, ss), d[15:0])
            `CHK("stat sel", 1'(set), d[SCOC_SYN_SET_BIT])
        end
        wr(SCOC_IDX_CTRL, 32'h0);
        tick(2);
        `CHK("set1 back", r_keep, r_div)
        wr(SCOC_IDX_P1, 32'h10);
        for (int i = 0; i < 6; i++) begin
            wr(SCOC_IDX_R1, {24'h0, rtab[i]});
            wr(SCOC_IDX_S1, {24'h0, stab[i]});
            tick(2);
            wr(SCOC_IDX_IRQ_STATUS, 32'h4);
            rd(SCOC_IDX_IRQ_STATUS, d);
            `CHK("range err", etab[i], d[SCOC_ST_RANGE_BIT])
        end
        wr(SCOC_IDX_CTRL, 32'h1 << SCOC_LOCK_PIN_EN_BIT);
        wait_lock(1'b1);
        rd(SCOC_IDX_IRQ_STATUS, d);
        `CHK("lock flag", 1'b1, d[SCOC_ST_LOCK_BIT])
        `CHK("lock pin", 1'b1, lock_pin)
        wr(SCOC_IDX_IRQ_MASK, 32'h1);
        tick(2);
        `CHK("irq on", 1'b1, irq)
        wr(SCOC_IDX_CTRL, 32'h0);
        tick(2);
        `CHK("pin gated", 1'b0, lock_pin)
        wr(SCOC_IDX_CTRL, 32'h1 << SCOC_LOCK_PIN_EN_BIT);
        kill_lock <= 1'b1;
        wait_lock(1'b0);
        rd(SCOC_IDX_IRQ_STATUS, d);
        `CHK("sticky", 2'h3, d[1:0])
        wr(SCOC_IDX_IRQ_STATUS, 32'h7);
        rd(SCOC_IDX_IRQ_STATUS, d);
        `CHK("w1c", 3'h0, d[SCOC_IRQ_W-1:0])
        `CHK("pin clr", 1'b0, lock_pin)
        `CHK("irq off", 1'b0, irq)
        kill_lock <= 1'b0;
        wait_lock(1'b1);
        `CHK("irq relock", 1'b1, irq)
        wr(SCOC_IDX_IRQ_MASK, 32'h0);
        tick(2);
        `CHK("irq masked", 1'b0, irq)
        rr = 8'($urandom);
        wr(SCOC_IDX_FREQ_DEV, {24'h0, rr});
        for (int i = 0; i < 4; i++) begin
            ook_mode <= i[1];
            tx_active <= i[0];
            tick(3);
            `CHK("lo ofs", lo_exp(i[1], i[0]), lo_offset_sel)
        end
        `CHK("fdev", rr, freq_deviation_field)
        // Only the band codes that the channel table allows
        for (int i = 0; i < 4; i++) begin
            wr(SCOC_IDX_CTRL, 32'(btab[i]) << SCOC_BAND_LSB
                | 32'(3 - i) << SCOC_TRIM_LSB);
            tick(2);
            `CHK("band", btab[i], band_select_field)
            `CHK("trim", 2'(3 - i), vco_trim_field)
        end
        wr(1, 32'hFFFFFFFF);
        rd(1, d);
        `CHK("unmapped", 32'h0, d)
        ahb(8'h19, 1'b0, 32'h0, d);
        `CHK("unaligned", 32'h0, d)
        report_and_stop();
    end
endmodule
